// ### bench/core_bus_model.sv
// core memory bus model: one write, then one read, write completed late
// assumes: guard answers sampled at the rising edge of clk_in
`timescale 1ns/1ps
`default_nettype none

module core_bus_model (
   // clock
   input  wire logic                      clk_in,
   // guard answers
   input  wire logic                      rd_ack_in,
   input  wire logic                      rd_stall_in,
   input  wire logic                      wr_ready_in,
   input  wire logic                      mem_rd_in,
   // requests to the guard
   output var  order_guard_pkg::rd_req_t   rd_out,
   output var  order_guard_pkg::wr_track_t wr_out
);
   import order_guard_pkg::*;

   initial begin
      rd_out = '0;
      wr_out = '0;
   end

   // -------------------------------------
   // write then read, done after hold cycles
   // -------------------------------------
   // lat stays -1 when no answer comes in 40 cycles
   task automatic wr_rd(input mem_addr_t wa, input mem_addr_t ra, input int hold,
                        output int lat, output logic stalled, output logic [1:0] seen);
      logic sent;
      sent = 1'b0;
      lat = -1;
      stalled = 1'b0;
      seen = 2'b00;
      wr_out <= '{issue: 1'b1, addr: wa, done: 1'b0};
      @(posedge clk_in);
      wr_out.issue <= 1'b0;
      rd_out <= '{req: 1'b1, addr: ra};
      for (int i = 1; i <= 40; i++) begin
         @(posedge clk_in);
         stalled |= rd_stall_in;
         if (i == 1) seen[0] = (wr_ready_in === 1'b0);
         wr_out.done <= (i == hold);
         sent |= (i == hold);
         if (rd_ack_in === 1'b1) begin
            lat = i;
            seen[1] = (mem_rd_in === 1'b1);
            break;
         end
      end
      // released lines carry garbage, not the last value
      rd_out <= '{req: 1'b0, addr: ~ra};
      if (!sent) begin
         @(posedge clk_in);
         wr_out.done <= 1'b1;
      end
      @(posedge clk_in);
      wr_out <= '{issue: 1'b0, addr: ~wa, done: 1'b0};
      @(posedge clk_in);
   endtask

endmodule

`default_nettype wire

// ### bench/write_read_order_guard_bench.sv
// self-checking bench of the write/read order guard
// assumes: core_bus_model drives the core side of the guard
`timescale 1ns/1ps
`default_nettype none

module write_read_order_guard_bench;
   import order_guard_pkg::*;
   localparam logic [15:0] PART = 16'h5A3C; // arbitrary value
   localparam logic [15:0] REV  = 16'h0003; // arbitrary value

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [11:0] r_addr = '0;
   logic [31:0] r_wdata = '0;
   logic        r_wr = 1'b0;
   logic        r_rd = 1'b0;
   logic [31:0] r_rdata;
   rd_req_t     rd;
   wr_track_t   wr;
   logic        ack, stall, wr_ready, mem_rd, guard_en;
   mem_addr_t   mem_rd_addr;
   int          fails = 0;
   int          n_compared = 0;

   always #5 clk = ~clk;

   write_read_order_guard #(.PART_CODE(PART), .REV_CODE(REV)) dut (
      .clk_sys_in(clk), .sys_rst_in(rst), .reg_addr_in(r_addr),
      .reg_wdata_in(r_wdata), .reg_wr_in(r_wr), .reg_rd_in(r_rd),
      .reg_rdata_out(r_rdata), .rd_in(rd), .wr_in(wr), .rd_ack_out(ack),
      .rd_stall_out(stall), .wr_ready_out(wr_ready), .mem_rd_out(mem_rd),
      .mem_rd_addr_out(mem_rd_addr), .guard_en_out(guard_en));

   core_bus_model u_core (.clk_in(clk), .rd_ack_in(ack), .rd_stall_in(stall),
                          .wr_ready_in(wr_ready), .mem_rd_in(mem_rd),
                          .rd_out(rd), .wr_out(wr));

   // -------------------------------------
   // shared tasks
   // -------------------------------------
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // gap cycle after each write keeps the strobe edges apart
   task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
      r_addr <= a;
      r_wdata <= d;
      r_wr <= 1'b1;
      @(posedge clk);
      r_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      r_addr <= a;
      r_rd <= 1'b1;
      @(posedge clk);
      r_rd <= 1'b0;
      @(posedge clk);
      chk(r_rdata, exp);
   endtask

   // write then read straight after, no gap between the strobes
   task automatic wr_rd_chk(input logic [11:0] a, input logic [31:0] d,
                            input logic [31:0] exp);
      r_addr <= a;
      r_wdata <= d;
      r_wr <= 1'b1;
      @(posedge clk);
      r_wr <= 1'b0;
      r_rd <= 1'b1;
      @(posedge clk);
      r_rd <= 1'b0;
      @(posedge clk);
      chk(r_rdata, exp);
   endtask

   // read latency 2 means no hold, hold+3 means held until the write was done
   task automatic acc(input mem_addr_t wa, input mem_addr_t ra, input int lat_exp);
      int         lat;
      logic       stl;
      logic [1:0] seen;
      u_core.wr_rd(wa, ra, 4, lat, stl, seen);
      if (lat < 0) begin
         fails++;
         end_of_test();
      end
      chk(32'(lat), 32'(lat_exp));
      chk({31'h0, stl}, {31'h0, lat_exp > 2});
      chk(32'(mem_rd_addr), 32'(ra));
      chk({30'h0, seen}, 32'h0000_0003);
      chk({31'h0, wr_ready}, 32'h0000_0001);
   endtask

   // -------------------------------------
   // scenarios
   // -------------------------------------
   task automatic t_reset();
      chk({31'h0, guard_en}, 32'h0000_0001);
      rd_chk(12'h880, 32'h000F_0040);
      rd_chk(12'h884, 32'h0000_0100);
      rd_chk(12'h885, 32'h0000_00FF);
      rd_chk(12'h882, {REV, PART});
      @(posedge clk);
      chk(r_rdata, 32'h0000_0000);
      $display("test reset values done");
   endtask

   task automatic t_read_only();
      reg_write(12'h882, 32'hFFFF_FFFF);
      rd_chk(12'h882, {REV, PART});
      reg_write(12'h886, 32'h1234_5678);
      rd_chk(12'h886, 32'h0000_0000);
      $display("test read-only done");
   endtask

   task automatic t_default_region();
      acc(22'h00_4000, 22'h00_7FC0, 7);
      acc(22'h00_4000, 22'h00_8000, 2);
      acc(22'h00_7FFF, 22'h00_3FFF, 2);
      acc(22'h00_4000, 22'h20_4000, 2);
      acc(22'h00_2100, 22'h00_2100, 7);
      $display("test default region done");
   endtask

   task automatic t_disabled();
      reg_write(12'h880, 32'h0000_0000);
      chk({31'h0, guard_en}, 32'h0000_0000);
      rd_chk(12'h880, 32'h0007_0040);
      acc(22'h00_4000, 22'h00_4001, 2);
      acc(22'h00_4001, 22'h00_4001, 7);
      reg_write(12'h880, 32'h0008_0000);
      chk({31'h0, guard_en}, 32'h0000_0001);
      $display("test guard disabled done");
   endtask

   task automatic t_new_region();
      wr_rd_chk(12'h884, 32'hFFFF_0040, 32'h0000_0040);
      wr_rd_chk(12'h885, 32'hFFFF_003F, 32'h0000_003F);
      acc(22'h00_1000, 22'h00_1FFF, 7);
      acc(22'h00_1000, 22'h00_2000, 2);
      acc(22'h00_1000, 22'h00_4000, 2);
      $display("test new region done");
   endtask

   // -------------------------------------
   // main sequence and hang cut-off
   // -------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_read_only();
      t_default_region();
      t_disabled();
      t_new_region();
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_of_test();
   end

endmodule

`default_nettype wire

// ### core/order_guard_cfg.svh
// constants of the write/read order guard: offsets, fields, resets
// assumes: included by the package and the design files by bare name
`ifndef ORDER_GUARD_CFG_SVH
`define ORDER_GUARD_CFG_SVH

// ---------------------------------------------
// register offsets (16-bit word addresses)
// ---------------------------------------------
`define REG_ADDR_W       12
`define OFS_DEV_CFG      12'h0880
`define OFS_CHIP_ID      12'h0882
`define OFS_REGION_START 12'h0884
`define OFS_REGION_SIZE  12'h0885

// ---------------------------------------------
// fields and reset values
// ---------------------------------------------
`define CFG_ENABLE_BIT   19
`define CFG_FIXED_ONES   32'h0007_0040
`define RST_ENABLE       1'b1
`define RST_REGION_START 16'h0100
`define RST_REGION_SIZE  16'h00FF
`define PART_LO          15
`define REV_LO           16
`define MEM_ADDR_W       22
`define GRAIN_BITS       6

`endif

// ### core/order_guard_pkg.sv
// types of the write/read order guard
// assumes: order_guard_cfg.svh on the include path
`include "order_guard_cfg.svh"

package order_guard_pkg;

   typedef enum logic [0:0] {
      ST_FREE = 1'b0,
      ST_HELD = 1'b1
   } guard_state_t;

   typedef logic [`MEM_ADDR_W-1:0] mem_addr_t;

   // read request bundle from the core
   typedef struct packed {
      logic      req;
      mem_addr_t addr;
   } rd_req_t;

   // write tracking bundle from the core
   typedef struct packed {
      logic      issue;
      mem_addr_t addr;
      logic      done;
   } wr_track_t;

   typedef struct packed {
      guard_state_t fsm;
      logic         pending;
      mem_addr_t    pend_addr;
      logic [15:0]  start;
      logic [15:0]  size;
      logic         enable;
      logic [31:0]  rdata;
      logic         rd_ack;
      logic         mem_rd;
      mem_addr_t    mem_rd_addr;
      logic         stall;
      logic         wr_ready;
   } guard_regs_t;

endpackage

// ### core/region_match.sv
// address-in-region compare of the order guard
// assumes: purely combinational, used inside the guard core
`timescale 1ns/1ps
`default_nettype none
`include "order_guard_cfg.svh"

module region_match (
   // address and region
   input  wire logic [`MEM_ADDR_W-1:0] addr_in,
   input  wire logic [15:0]            start_in,
   input  wire logic [15:0]            size_in,
   // result
   output logic                        hit_out
);

   // ---------------------------------------------
   // masked compare on 64-word blocks
   // ---------------------------------------------
   always_comb begin
      hit_out = ((addr_in[`MEM_ADDR_W-1:`GRAIN_BITS] & ~size_in) ==
                 (start_in & ~size_in));
   end

endmodule
`default_nettype wire

// ### core/write_read_order_guard.sv
// write/read order guard with chip identification registers
// assumes: one write outstanding at a time, core honours wr_ready_out
//
// Behaviour
// - identification register low half reads the part number code
// - identification register high half reads the silicon revision
// - with guard on, read after write both in region stalls until write done
// - with guard off, a read to another address may pass a pending write
// - a read to the same address as a pending write always waits
// - region start is 16-bit read/write, address bits 21:6, resets 0x0100
// - region size is low-order ones mask of 64-word blocks, resets 0x00FF
// - reset values cover addresses 0x4000 up to 0x7FFF
// - configuration bit 19 enables the guard, resets to one
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "order_guard_cfg.svh"

module write_read_order_guard #(
   parameter logic [15:0] PART_CODE = 16'h00A5, // arbitrary value
   parameter logic [15:0] REV_CODE  = 16'h0010  // arbitrary value
) (
   // clock and reset
   input  wire logic                    clk_sys_in,
   input  wire logic                    sys_rst_in,
   // register port
   input  wire logic [`REG_ADDR_W-1:0]  reg_addr_in,
   input  wire logic [31:0]             reg_wdata_in,
   input  wire logic                    reg_wr_in,
   input  wire logic                    reg_rd_in,
   output logic      [31:0]             reg_rdata_out,
   // core memory bus
   input  wire order_guard_pkg::rd_req_t   rd_in,
   input  wire order_guard_pkg::wr_track_t wr_in,
   output logic                         rd_ack_out,
   output logic                         rd_stall_out,
   output logic                         wr_ready_out,
   output logic                         mem_rd_out,
   output order_guard_pkg::mem_addr_t   mem_rd_addr_out,
   output logic                         guard_en_out
);
   import order_guard_pkg::*;

   guard_regs_t st_r;
   guard_regs_t st_nxt;

   mem_addr_t   wr_addr_eff;
   logic        wr_pend_eff;
   logic        hit_rd;
   logic        hit_wr;
   logic        hazard;

   // ---------------------------------------------
   // region compares
   // ---------------------------------------------
   region_match u_hit_rd (
      .addr_in  (rd_in.addr),
      .start_in (st_r.start),
      .size_in  (st_r.size),
      .hit_out  (hit_rd)
   );

   region_match u_hit_wr (
      .addr_in  (wr_addr_eff),
      .start_in (st_r.start),
      .size_in  (st_r.size),
      .hit_out  (hit_wr)
   );

   // ---------------------------------------------
   // hazard decision
   // ---------------------------------------------
   // a write issued this very cycle is older in program order than the read
   always_comb begin
      wr_pend_eff = st_r.pending | wr_in.issue;
      wr_addr_eff = wr_in.issue ? wr_in.addr : st_r.pend_addr;
      hazard      = 1'b0;
      if (wr_pend_eff && (rd_in.addr == wr_addr_eff)) begin
         hazard = 1'b1;
      end
      else if (wr_pend_eff && st_r.enable && hit_rd && hit_wr) begin
         hazard = 1'b1;
      end
      // guard off and no address match: read is free to pass
   end

   // ---------------------------------------------
   // next state
   // ---------------------------------------------
   always_comb begin
      st_nxt        = st_r;
      st_nxt.rdata  = 32'h0000_0000;
      st_nxt.rd_ack = 1'b0;
      st_nxt.mem_rd = 1'b0;

      // write tracking, a new issue wins over a completion
      st_nxt.pending = wr_in.issue | (st_r.pending & ~wr_in.done);
      if (wr_in.issue) begin
         st_nxt.pend_addr = wr_in.addr;
      end
      st_nxt.wr_ready = ~st_nxt.pending;

      // read arbitration; ack guard stops a second take of one request
      case (st_r.fsm)
         ST_FREE,
         ST_HELD: begin
            if (rd_in.req && !st_r.rd_ack) begin
               if (hazard) begin
                  st_nxt.fsm   = ST_HELD;
                  st_nxt.stall = 1'b1;
               end
               else begin
                  st_nxt.fsm         = ST_FREE;
                  st_nxt.stall       = 1'b0;
                  st_nxt.rd_ack      = 1'b1;
                  st_nxt.mem_rd      = 1'b1;
                  st_nxt.mem_rd_addr = rd_in.addr;
               end
            end
            else begin
               st_nxt.fsm   = ST_FREE;
               st_nxt.stall = 1'b0;
            end
         end
         default: begin
            st_nxt.fsm   = ST_FREE;
            st_nxt.stall = 1'b0;
         end
      endcase

      // register writes
      if (reg_wr_in) begin
         case (reg_addr_in)
            `OFS_DEV_CFG:      st_nxt.enable = reg_wdata_in[`CFG_ENABLE_BIT];
            `OFS_REGION_START: st_nxt.start  = reg_wdata_in[15:0];
            `OFS_REGION_SIZE:  st_nxt.size   = reg_wdata_in[15:0];
            default: ;
         endcase
      end

      // register reads, data stand one cycle only; unmapped reads zero
      if (reg_rd_in) begin
         case (reg_addr_in)
            `OFS_DEV_CFG: begin
               st_nxt.rdata = `CFG_FIXED_ONES;
               st_nxt.rdata[`CFG_ENABLE_BIT] = st_r.enable;
            end
            `OFS_CHIP_ID:      st_nxt.rdata = {REV_CODE, PART_CODE};
            `OFS_REGION_START: st_nxt.rdata = {16'h0000, st_r.start};
            `OFS_REGION_SIZE:  st_nxt.rdata = {16'h0000, st_r.size};
            default:           st_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------
   // state register
   // ---------------------------------------------
   // reset region covers 0x4000..0x7FFF; start alignment is software's job
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         st_r             <= '0;
         st_r.fsm         <= ST_FREE;
         st_r.start       <= `RST_REGION_START;
         st_r.size        <= `RST_REGION_SIZE;
         st_r.enable      <= `RST_ENABLE;
         st_r.wr_ready    <= 1'b1;
      end
      else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------
   // outputs, all straight from flops
   // ---------------------------------------------
   always_comb begin
      reg_rdata_out   = st_r.rdata;
      rd_ack_out      = st_r.rd_ack;
      rd_stall_out    = st_r.stall;
      wr_ready_out    = st_r.wr_ready;
      mem_rd_out      = st_r.mem_rd;
      mem_rd_addr_out = st_r.mem_rd_addr;
      guard_en_out    = st_r.enable;
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   // reset-region probes for fixed addresses
   logic probe_lo;
   logic probe_hi;
   logic probe_out;
   always_comb begin
      probe_lo  = ((16'h0100 & ~st_r.size) == (st_r.start & ~st_r.size));
      probe_hi  = ((16'h01FF & ~st_r.size) == (st_r.start & ~st_r.size));
      probe_out = ((16'h0200 & ~st_r.size) == (st_r.start & ~st_r.size));
   end

   property p_part_id;
      reg_rd_in && reg_addr_in == `OFS_CHIP_ID |=> reg_rdata_out[15:0] == PART_CODE;
   endproperty
   a_part_id: assert property (p_part_id) else $error("part number wrong");

   property p_rev_id;
      reg_rd_in && reg_addr_in == `OFS_CHIP_ID |=> reg_rdata_out[31:16] == REV_CODE;
   endproperty
   a_rev_id: assert property (p_rev_id) else $error("revision wrong");

   property p_region_stall;
      rd_in.req && !rd_ack_out && st_r.enable && st_r.pending && !wr_in.done
         && hit_rd && hit_wr
         |=> rd_stall_out && !rd_ack_out && !mem_rd_out;
   endproperty
   a_region_stall: assert property (p_region_stall) else $error("read passed write");

   property p_pass_free;
      rd_in.req && !rd_ack_out && !st_r.enable && !wr_in.issue && st_r.pending
         && rd_in.addr != st_r.pend_addr
         |=> rd_ack_out && mem_rd_out && mem_rd_addr_out == $past(rd_in.addr);
   endproperty
   a_pass_free: assert property (p_pass_free) else $error("read held needlessly");

   property p_same_addr;
      rd_in.req && !rd_ack_out && st_r.pending && rd_in.addr == st_r.pend_addr
         |=> !mem_rd_out;
   endproperty
   a_same_addr: assert property (p_same_addr) else $error("same address reordered");

   property p_start_rw;
      reg_wr_in && reg_addr_in == `OFS_REGION_START ##1
         reg_rd_in && reg_addr_in == `OFS_REGION_START
         |=> reg_rdata_out == {16'h0000, $past(reg_wdata_in[15:0], 2)};
   endproperty
   a_start_rw: assert property (p_start_rw) else $error("start readback");

   property p_size_rw;
      reg_wr_in && reg_addr_in == `OFS_REGION_SIZE |=> st_r.size == $past(reg_wdata_in[15:0]);
   endproperty
   a_size_rw: assert property (p_size_rw) else $error("size not stored");

   property p_reset_region;
      $past(sys_rst_in) |-> probe_lo && probe_hi && !probe_out;
   endproperty
   a_reset_region: assert property (p_reset_region) else $error("reset region");

   property p_enable_bit;
      reg_wr_in && reg_addr_in == `OFS_DEV_CFG |=> guard_en_out == $past(reg_wdata_in[19]);
   endproperty
   a_enable_bit: assert property (p_enable_bit) else $error("enable bit");

   // ---------------------------------------------
   // contract checks
   // ---------------------------------------------
   property p_size_readback;
      reg_wr_in && reg_addr_in == `OFS_REGION_SIZE ##1
         reg_rd_in && reg_addr_in == `OFS_REGION_SIZE
         |=> reg_rdata_out == {16'h0000, $past(reg_wdata_in[15:0], 2)};
   endproperty
   a_size_readback: assert property (p_size_readback) else $error("size readback");

   // fixed ones and spares must not move with the enable bit
   property p_cfg_fixed;
      reg_rd_in && reg_addr_in == `OFS_DEV_CFG
         |=> (reg_rdata_out & ~(32'h0000_0001 << `CFG_ENABLE_BIT)) == `CFG_FIXED_ONES
             && reg_rdata_out[`CFG_ENABLE_BIT] == $past(guard_en_out);
   endproperty
   a_cfg_fixed: assert property (p_cfg_fixed) else $error("config readback");

   property p_region_free;
      rd_in.req && !rd_ack_out && st_r.enable && st_r.pending && !wr_in.issue && !hit_rd
         && rd_in.addr != st_r.pend_addr
         |=> rd_ack_out && mem_rd_out;
   endproperty
   a_region_free: assert property (p_region_free) else $error("outside read held");

   property p_ack_pulse;
      rd_ack_out |=> !rd_ack_out && !mem_rd_out;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");

   property p_wr_busy;
      wr_in.issue |=> !wr_ready_out;
   endproperty
   a_wr_busy: assert property (p_wr_busy) else $error("ready after issue");

   property p_wr_free;
      st_r.pending && wr_in.done && !wr_in.issue |=> wr_ready_out;
   endproperty
   a_wr_free: assert property (p_wr_free) else $error("ready not back");

   property p_rdata_idle;
      !reg_rd_in |=> reg_rdata_out == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data stands");

   c_stall:   cover property (rd_stall_out ##1 rd_stall_out);
   c_release: cover property (rd_stall_out ##[1:20] rd_ack_out);
   c_pass:    cover property (st_r.pending && mem_rd_out);
   c_same:    cover property (st_r.pending && rd_in.req && rd_in.addr == st_r.pend_addr
                              ##1 rd_stall_out);

endmodule
`default_nettype wire
